// >>> design/glcd_pkg.sv
/*
 * Constants shared by the instrument bus listener and command decoder.
 * Assumes a single 40 MHz clock domain and an active-low bus with the
 * pin levels already inverted to active-high at the pad ring.
 */
package glcd_pkg;

	localparam logic [7:0] GLCD_GTL_C  = 8'h01;
	localparam logic [7:0] GLCD_SDC_C  = 8'h04;
	localparam logic [7:0] GLCD_DCL_C  = 8'h14;
	localparam logic [7:0] GLCD_SPE_C  = 8'h18;
	localparam logic [7:0] GLCD_SPD_C  = 8'h19;
	localparam logic [7:0] GLCD_UNL_C  = 8'h3f;
	localparam logic [7:0] GLCD_UNT_C  = 8'h5f;
	localparam logic [1:0] GLCD_LAG_C  = 2'h1;
	localparam logic [1:0] GLCD_TAG_C  = 2'h2;
	localparam logic [4:0] GLCD_ADDR_RST_C = 5'h07;
	localparam int         GLCD_RQS_BIT_C  = 6;

	typedef enum logic [1:0] {
		GLCD_HS_IDLE,
		GLCD_HS_TAKE,
		GLCD_HS_DONE
	} glcd_hs_t;

	typedef enum logic [1:0] {
		GLCD_TX_IDLE,
		GLCD_TX_WAIT,
		GLCD_TX_VALID
	} glcd_tx_t;

endpackage

// >>> design/glcd_skid.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes the filler and drainer share the clock of the instance.
 */
module glcd_skid
	import glcd_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	// Fill side.
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side.
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	if (WIDTH < 1) begin : g_width_chk
		$error("WIDTH must be positive");
	end

	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o  = mem_q[rd_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) wr_q <= ~wr_q;
			if (pop) rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	AST_NO_OVERFLOW: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cnt_q <= 2'h2)
		else $error("buffer count above two");

endmodule

// >>> design/glcd_top.sv
/*
 * Device end of the instrument bus: acceptor and source handshakes,
 * command decoder, addressing, clears, remote and serial poll.
 * Assumes bus pins already inverted to active-high at the pads and an
 * external open-collector driver for the outputs it enables.
 */
module glcd_top
	import glcd_pkg::*;
(
	// Clock and reset.
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	// Bus lines, active-high after pad inversion.
	input  wire logic [7:0] dio_i,
	output logic [7:0]      dio_o,
	output logic            dio_oe_n_o,
	input  wire logic       atn_i,
	input  wire logic       ifc_i,
	input  wire logic       ren_i,
	input  wire logic       dav_i,
	output logic            dav_o,
	output logic            dav_oe_n_o,
	input  wire logic       nrfd_i,
	output logic            nrfd_o,
	output logic            nrfd_oe_n_o,
	input  wire logic       ndac_i,
	output logic            ndac_o,
	output logic            ndac_oe_n_o,
	// Device side.
	input  wire logic [4:0] addr_i,
	input  wire logic [6:0] status_i,
	input  wire logic       srq_pend_i,
	output logic            rx_valid_o,
	input  wire logic       rx_ready_i,
	output logic [7:0]      rx_data_o,
	output logic            dev_clr_o,
	output logic            listener_o,
	output logic            talker_o,
	output logic            remote_o,
	output logic            spoll_o
);

	logic [7:0] dio_s1_q, dio_s2_q;
	logic [5:0] sync1_q, sync2_q;
	logic       atn, ifc, ren, dav, nrfd, ndac;
	logic [4:0] addr_s1_q, addr_q;
	glcd_hs_t   hs_q;
	glcd_tx_t   tx_q;
	logic [7:0] byte_q;
	logic       take;
	logic       acc_off;
	logic       is_cmd_q;
	logic       lacs_q, tacs_q, rem_q, spe_q, clr_q;
	logic       buf_ready;

	// Bus inputs cross into the clock domain through two flops.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dio_s1_q <= 8'h00;
			dio_s2_q <= 8'h00;
			sync1_q  <= 6'h00;
			sync2_q  <= 6'h00;
		end else begin
			dio_s1_q <= dio_i;
			dio_s2_q <= dio_s1_q;
			sync1_q  <= {atn_i, ifc_i, ren_i, dav_i, nrfd_i, ndac_i};
			sync2_q  <= sync1_q;
		end
	end
	assign {atn, ifc, ren, dav, nrfd, ndac} = sync2_q;

	// The address strap is a pin too, so it is synchronised like the
	// bus lines; a live change is seen two cycles later.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_s1_q <= GLCD_ADDR_RST_C;
			addr_q    <= GLCD_ADDR_RST_C;
		end else begin
			addr_s1_q <= addr_i;
			addr_q    <= addr_s1_q;
		end
	end

	// Acceptor: a byte is taken only when the buffer can hold it, so a
	// stalled receiver holds NRFD and nothing is lost.
	assign take = (hs_q == GLCD_HS_IDLE) && dav && buf_ready;
	// A talker still accepts every byte sent under attention, or it
	// could never be untalked; it only stands aside from data bytes.
	assign acc_off = tacs_q && !atn;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hs_q     <= GLCD_HS_IDLE;
			byte_q   <= 8'h00;
			is_cmd_q <= 1'b0;
		end else begin
			case (hs_q)
			GLCD_HS_IDLE: begin
				if (take && !acc_off) begin
					hs_q     <= GLCD_HS_TAKE;
					byte_q   <= dio_s2_q;
					is_cmd_q <= atn;
				end
			end
			GLCD_HS_TAKE: hs_q <= GLCD_HS_DONE;
			GLCD_HS_DONE: if (!dav) hs_q <= GLCD_HS_IDLE;
			default: hs_q <= GLCD_HS_IDLE;
			endcase
		end
	end

	logic cmd_stb, data_stb;
	assign cmd_stb  = (hs_q == GLCD_HS_TAKE) && is_cmd_q;
	assign data_stb = (hs_q == GLCD_HS_TAKE) && !is_cmd_q && lacs_q;

	// Addressing, clears, remote and serial poll.
	logic [7:0] b;
	assign b = byte_q & 8'h7f;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lacs_q <= 1'b0;
			tacs_q <= 1'b0;
			spe_q  <= 1'b0;
			rem_q  <= 1'b0;
			clr_q  <= 1'b0;
		end else begin
			clr_q <= 1'b0;
			if (!ren) rem_q <= 1'b0;
			if (ifc) begin
				lacs_q <= 1'b0;
				tacs_q <= 1'b0;
				spe_q  <= 1'b0;
			end else if (cmd_stb) begin
				if (b == GLCD_UNL_C) begin
					lacs_q <= 1'b0;
				end else if (b == {1'b0, GLCD_LAG_C, addr_q}) begin
					lacs_q <= 1'b1;
					if (ren) rem_q <= 1'b1;
				end else if (b == GLCD_UNT_C) begin
					tacs_q <= 1'b0;
				end else if (b == {1'b0, GLCD_TAG_C, addr_q}) begin
					tacs_q <= 1'b1;
				end else if (b[6:5] == GLCD_TAG_C) begin
					tacs_q <= 1'b0;
				end else if (b == GLCD_DCL_C) begin
					clr_q <= 1'b1;
				end else if (b == GLCD_SPE_C) begin
					spe_q <= 1'b1;
				end else if (b == GLCD_SPD_C) begin
					spe_q <= 1'b0;
				end else if (b == GLCD_SDC_C && lacs_q) begin
					clr_q <= 1'b1;
				end else if (b == GLCD_GTL_C && lacs_q) begin
					rem_q <= 1'b0;
				end
			end
		end
	end

	// Acceptor pin drive: NRFD while not idle or buffer full, NDAC
	// until the byte is latched. A talker with attention released lets
	// both lines go.
	assign nrfd_o      = 1'b1;
	assign nrfd_oe_n_o = acc_off ? 1'b1 :
		!((hs_q != GLCD_HS_IDLE) || !buf_ready);
	assign ndac_o      = 1'b1;
	assign ndac_oe_n_o = acc_off ? 1'b1 :
		!((hs_q == GLCD_HS_IDLE) && !take);

	glcd_skid #(
		.WIDTH(8)
	) u_buf (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.in_valid_i (data_stb),
		.in_ready_o (buf_ready),
		.in_data_i  (byte_q),
		.out_valid_o(rx_valid_o),
		.out_ready_i(rx_ready_i),
		.out_data_o (rx_data_o)
	);

	// Source: only the serial poll status byte is sent from here.
	logic [7:0] stb_q;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_q  <= GLCD_TX_IDLE;
			stb_q <= 8'h00;
		end else begin
			case (tx_q)
			GLCD_TX_IDLE: begin
				if (tacs_q && spe_q && !atn) begin
					stb_q <= {1'b0, status_i};
					stb_q[GLCD_RQS_BIT_C] <= srq_pend_i;
					tx_q  <= GLCD_TX_WAIT;
				end
			end
			GLCD_TX_WAIT: begin
				if (atn || !tacs_q) tx_q <= GLCD_TX_IDLE;
				else if (!nrfd) tx_q <= GLCD_TX_VALID;
			end
			GLCD_TX_VALID: begin
				if (!ndac || atn || !tacs_q) tx_q <= GLCD_TX_IDLE;
			end
			default: tx_q <= GLCD_TX_IDLE;
			endcase
		end
	end

	assign dio_o      = stb_q;
	assign dio_oe_n_o = !(tx_q != GLCD_TX_IDLE);
	assign dav_o      = 1'b1;
	assign dav_oe_n_o = !(tx_q == GLCD_TX_VALID);
	assign dev_clr_o  = clr_q;
	assign listener_o = lacs_q;
	assign talker_o   = tacs_q;
	assign remote_o   = rem_q;
	assign spoll_o    = spe_q;

	sequence s_sdc_unaddr;
		cmd_stb && b == GLCD_SDC_C && !lacs_q;
	endsequence

	AST_SDC_NEEDS_LISTEN: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) s_sdc_unaddr |=> !clr_q)
		else $error("unaddressed selective clear acted");
	AST_MLA: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_stb && !ifc && b == {1'b0, GLCD_LAG_C, addr_q} |=> lacs_q)
		else $error("own listen address ignored");
	AST_SDC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_stb && !ifc && b == GLCD_SDC_C && lacs_q |=> clr_q)
		else $error("selective clear missed");
	AST_DATA: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) data_stb |-> buf_ready)
		else $error("data byte offered to a full buffer");
	AST_DAV_NRFD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(tx_q == GLCD_TX_VALID) |-> $past(!nrfd))
		else $error("source asserted valid while not ready");
	AST_IFC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ifc |=> !lacs_q && !tacs_q && !spe_q)
		else $error("interface clear ignored");
	sequence s_poll_arm;
		tx_q == GLCD_TX_IDLE && tacs_q && spe_q && !atn;
	endsequence

	AST_SPOLL: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		s_poll_arm |=> dio_o[GLCD_RQS_BIT_C] == $past(srq_pend_i))
		else $error("service request bit not loaded");
	AST_UNT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_stb && !ifc && b == GLCD_UNT_C |=> !tacs_q)
		else $error("untalk ignored");
	AST_MTA: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_stb && !ifc && b == {1'b0, GLCD_TAG_C, addr_q} |=> tacs_q)
		else $error("own talk address ignored");
	AST_GTL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_stb && !ifc && b == GLCD_GTL_C && lacs_q |=> !rem_q)
		else $error("go to local ignored");
	AST_DCL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_stb && !ifc && b == GLCD_DCL_C |=> clr_q)
		else $error("device clear missed");
	AST_CMD_NOT_DATA: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		take && !acc_off |=> hs_q == GLCD_HS_TAKE && is_cmd_q == $past(atn))
		else $error("attention level not kept with the byte");

endmodule

// >>> bench/glcd_ctl_model.sv
/*
 * Behavioural bus controller that sources command and data bytes.
 * Assumes active-high levels on the device side of the pads.
 */
module glcd_ctl_model
	import glcd_pkg::*;
(
	// Clock.
	input  wire logic  ref_clk_i,
	// Controller lines.
	output logic [7:0] dio_o,
	output logic       atn_o,
	output logic       dav_o,
	output logic       ifc_o,
	output logic       ren_o,
	output logic       nrfd_o,
	output logic       ndac_o,
	// Device handshake enables.
	input  wire logic  nrfd_oe_n_i,
	input  wire logic  ndac_oe_n_i
);
	timeunit 1ns;
	timeprecision 1ps;

	int n_stall;
	int n_bad;

	initial begin
		dio_o = 8'h00;
		atn_o = 1'b0;
		dav_o = 1'b0;
		ifc_o = 1'b0;
		ren_o = 1'b0;
		nrfd_o = 1'b0;
		ndac_o = 1'b1;
		n_stall = 0;
		n_bad = 0;
	end

	// Waits at most 64 cycles for the device ready line to reach lvl.
	task automatic wait_nrfd(input logic lvl);
		int n;
		n = 0;
		while (nrfd_oe_n_i !== lvl && n < 64) begin
			@(posedge ref_clk_i);
			#2;
			n++;
		end
		if (n == 64)
			n_stall++;
	endtask

	// Call just after a rising edge; ATN is set with the byte.
	task automatic send(input logic [7:0] b, input logic a);
		wait_nrfd(1'b1);
		// The device must hold NDAC until it has the byte.
		if (ndac_oe_n_i !== 1'b0)
			n_bad++;
		atn_o = a;
		dio_o = b;
		dav_o = 1'b1;
		wait_nrfd(1'b0);
		if (ndac_oe_n_i !== 1'b1)
			n_bad++;
		dav_o = 1'b0;
		// A released bus must not keep showing the last byte.
		dio_o = ~b;
		wait_nrfd(1'b1);
		repeat (3) @(posedge ref_clk_i);
		#2;
	endtask
endmodule

// >>> bench/tb.sv
/*
 * Self-checking bench for the device end of the instrument bus.
 * Assumes the controller model in the same folder.
 */
module tb;
	import glcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic       ref_clk, rst_n, rx_ready, srq;
	logic [7:0] dio, dio_o, rx_data;
	logic [6:0] status;
	logic       atn, ifc, ren, dav, nrfd, dio_oe_n, dav_oe_n, nrfd_oe_n;
	logic       ndac, ndac_oe_n;
	logic       rx_valid, dev_clr, listener, talker, remote, spoll;
	logic [15:0] lfsr_q;
	logic [7:0]  exp_q[$];
	int          n_errors, n_checks, n_clr;

	glcd_ctl_model ctl_u (.ref_clk_i(ref_clk), .dio_o(dio), .atn_o(atn),
		.dav_o(dav), .ifc_o(ifc), .ren_o(ren), .nrfd_o(nrfd), .ndac_o(ndac),
		.nrfd_oe_n_i(nrfd_oe_n), .ndac_oe_n_i(ndac_oe_n));

	glcd_top dut_u (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .dio_i(dio),
		.dio_o(dio_o), .dio_oe_n_o(dio_oe_n), .atn_i(atn), .ifc_i(ifc),
		.ren_i(ren), .dav_i(dav), .dav_o(), .dav_oe_n_o(dav_oe_n),
		.nrfd_i(nrfd), .nrfd_o(), .nrfd_oe_n_o(nrfd_oe_n), .ndac_i(ndac),
		.ndac_o(), .ndac_oe_n_o(ndac_oe_n), .addr_i(5'h07), .status_i(status),
		.srq_pend_i(srq), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
		.rx_data_o(rx_data), .dev_clr_o(dev_clr), .listener_o(listener),
		.talker_o(talker), .remote_o(remote), .spoll_o(spoll));

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	// Random stalls on the receive side and random status bits.
	always @(posedge ref_clk) begin
		#2;
		lfsr_q = lfsr(lfsr_q);
		rx_ready = lfsr_q[0] | lfsr_q[3];
		status = lfsr_q[13:7];
	end

	always @(posedge ref_clk) begin
		if (dev_clr === 1'b1)
			n_clr++;
		if (rst_n && rx_valid === 1'b1 && rx_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk(rx_data, 8'hxx);
			else
				chk(rx_data, exp_q.pop_front());
		end
	end

	initial begin
		#(25ns * 20000);
		n_errors++;
		finish_test();
	end

	initial begin
		logic [7:0] d[5];
		logic [7:0] seen;
		int n;
		n_errors = 0;
		n_checks = 0;
		n_clr = 0;
		lfsr_q = 16'h8fa2;
		rx_ready = 1'b0;
		status = 7'h00;
		srq = 1'b1;
		rst_n = 1'b0;
		repeat (20) @(posedge ref_clk);
		#2;
		rst_n = 1'b1;
		repeat (2) @(posedge ref_clk);
		#2;
		ctl_u.send(8'h55, 1'b0);
		ctl_u.send(GLCD_UNL_C, 1'b1);
		ctl_u.send(GLCD_SDC_C, 1'b1);
		chk(8'(n_clr), 8'h00);
		ctl_u.ren_o = 1'b1;
		ctl_u.send(8'h27, 1'b1);
		chk({6'h00, listener, remote}, 8'h03);
		d = '{8'h2a, 8'h52, 8'h53, 8'h54, lfsr_q[7:0]};
		foreach (d[i]) begin
			exp_q.push_back(d[i]);
			ctl_u.send(d[i], 1'b0);
		end
		ctl_u.send(GLCD_SDC_C, 1'b1);
		chk(8'(n_clr), 8'h01);
		ctl_u.send(GLCD_GTL_C, 1'b1);
		chk({7'h00, remote}, 8'h00);
		ctl_u.send(GLCD_UNL_C, 1'b1);
		chk({7'h00, listener}, 8'h00);
		ctl_u.send(GLCD_DCL_C, 1'b1);
		chk(8'(n_clr), 8'h02);
		ctl_u.send(8'h47, 1'b1);
		ctl_u.send(GLCD_SPE_C, 1'b1);
		chk({6'h00, talker, spoll}, 8'h03);
		srq = lfsr_q[4];
		ctl_u.atn_o = 1'b0;
		n = 0;
		while (dav_oe_n !== 1'b0 && n < 40) begin
			@(posedge ref_clk);
			#2;
			n++;
		end
		seen = {5'h00, dav_oe_n, dio_oe_n, dio_o[GLCD_RQS_BIT_C]};
		chk(seen, {7'h00, srq});
		// Accept the status byte and refuse a second one: DAV must drop
		// and stay off while NRFD is held.
		ctl_u.nrfd_o = 1'b1;
		ctl_u.ndac_o = 1'b0;
		n = 0;
		while (dav_oe_n !== 1'b1 && n < 8) begin
			@(posedge ref_clk);
			#2;
			n++;
		end
		repeat (4) @(posedge ref_clk);
		#2;
		chk({7'h00, dav_oe_n}, 8'h01);
		ctl_u.atn_o = 1'b1;
		ctl_u.nrfd_o = 1'b0;
		ctl_u.ndac_o = 1'b1;
		repeat (4) @(posedge ref_clk);
		#2;
		ctl_u.send(GLCD_SPD_C, 1'b1);
		chk({7'h00, spoll}, 8'h00);
		ctl_u.send(8'h45, 1'b1);
		chk({7'h00, talker}, 8'h00);
		ctl_u.send(8'h47, 1'b1);
		ctl_u.send(GLCD_UNT_C, 1'b1);
		chk({7'h00, talker}, 8'h00);
		ctl_u.send(8'h27, 1'b1);
		ctl_u.send(8'h47, 1'b1);
		ctl_u.ifc_o = 1'b1;
		ctl_u.ren_o = 1'b0;
		repeat (4) @(posedge ref_clk);
		#2;
		ctl_u.ifc_o = 1'b0;
		repeat (4) @(posedge ref_clk);
		#2;
		chk({5'h00, listener, talker, remote}, 8'h00);
		repeat (20) @(posedge ref_clk);
		chk(8'(exp_q.size()), 8'h00);
		chk(8'(ctl_u.n_stall), 8'h00);
		chk(8'(ctl_u.n_bad), 8'h00);
		finish_test();
	end
endmodule
